// ==== core/gpx_port.sv ====
// general purpose six-pin port with external interrupt vectors
//
// Local design decisions: the APB register port and the placing of the registers.
module gpx_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpx_pkg::NPINS-1:0] pad_in,
  output logic [gpx_pkg::NPINS-1:0] pad_out,
  output logic [gpx_pkg::NPINS-1:0] pad_oe,
  output logic [gpx_pkg::NPINS-1:0] pad_pullup_en,
  input wire logic [gpx_pkg::NPINS-1:0] alt_out_en,
  input wire logic [gpx_pkg::NPINS-1:0] alt_out_val,
  input wire logic [gpx_pkg::NPINS-1:0] alt_open_drain,
  output logic [gpx_pkg::NPINS-1:0] alt_in,
  input wire logic [gpx_pkg::NVEC-1:0] vec_fetch,
  output logic [gpx_pkg::NVEC-1:0] ext_irq_req
);
  import gpx_pkg::*;

  gpx_regbus_if rb ();

  logic [NPINS-1:0] pin_s;
  logic [NPINS-1:0] data_r;
  logic [NPINS-1:0] data_nxt;
  logic [NPINS-1:0] dir_r;
  logic [NPINS-1:0] dir_nxt;
  logic [NPINS-1:0] opt_r;
  logic [NPINS-1:0] opt_nxt;
  logic [2*NVEC-1:0] sens_r;
  logic [2*NVEC-1:0] sens_nxt;
  logic [NVEC-1:0] pend_r;
  logic [NVEC-1:0] pend_nxt;
  logic [NVEC-1:0] prev_r;
  logic [NVEC-1:0] prev_nxt;
  logic [NPINS-1:0] pad_out_r;
  logic [NPINS-1:0] pad_out_nxt;
  logic [NPINS-1:0] pad_oe_r;
  logic [NPINS-1:0] pad_oe_nxt;
  logic [NPINS-1:0] pad_pu_r;
  logic [NPINS-1:0] pad_pu_nxt;
  logic [NPINS-1:0] dir_eff;
  logic [NPINS-1:0] det_in;
  logic [NPINS-1:0] rd_pins;
  logic [NVEC-1:0] vec_lvl;
  logic [NVEC-1:0] vec_evt;
  logic [NVEC-1:0] sens_chg;
  logic wr_data;
  logic wr_dir;
  logic wr_opt;
  logic wr_sens;

  // register bus slave
  gpx_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rb(rb.slave)
  );

  // pad input synchroniser
  gpx_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pad_in),
    .q(pin_s)
  );

  // write strobes per register
  assign wr_data = rb.wr_en && (rb.idx == IDX_DATA);
  assign wr_dir = rb.wr_en && (rb.idx == IDX_DIR);
  assign wr_opt = rb.wr_en && (rb.idx == IDX_OPT);
  assign wr_sens = rb.wr_en && (rb.idx == IDX_SENS);

  // a peripheral output forces the pin into output mode
  assign dir_eff = dir_r | alt_out_en;

  // per-pin detector input and read value
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      if (gi == OUT_ONLY_PIN) begin : g_oonly
        // output-only pin never reaches detection or the read path
        assign det_in[gi] = 1'b1;
        assign rd_pins[gi] = alt_out_en[gi] ? alt_out_val[gi] : data_r[gi];
      end else begin : g_io
        // interrupt disabled or output: detector sees a steady one
        assign det_in[gi] = (!dir_eff[gi] && opt_r[gi]) ?
                            pin_s[gi] : 1'b1;
        // input reads the synchronised pin, output reads peripheral value or latch
        assign rd_pins[gi] = !dir_eff[gi] ? pin_s[gi] :
                             (alt_out_en[gi] ? alt_out_val[gi] :
                              data_r[gi]);
      end
    end
  endgenerate

  assign rb.rdata = (rb.idx == IDX_DATA) ? {2'b00, rd_pins} :
                    (rb.idx == IDX_DIR) ? {2'b00, dir_r} :
                    (rb.idx == IDX_OPT) ? {2'b00, opt_r} :
                    {2'b00, sens_r};

  // configuration registers; data latch is written in every mode
  always_comb begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    opt_nxt = opt_r;
    sens_nxt = sens_r;
    if (wr_data) begin
      data_nxt = rb.wdata[NPINS-1:0];
    end
    if (wr_dir) begin
      dir_nxt = rb.wdata[NPINS-1:0];
      dir_nxt[OUT_ONLY_PIN] = 1'b1;
    end
    if (wr_opt) begin
      opt_nxt = rb.wdata[NPINS-1:0];
    end
    if (wr_sens) begin
      sens_nxt = rb.wdata[2*NVEC-1:0];
    end
  end

  // configuration flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= RST_DATA;
      dir_r <= RST_DIR;
      opt_r <= RST_OPT;
      sens_r <= RST_SENS;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      opt_r <= opt_nxt;
      sens_r <= sens_nxt;
    end
  end

  // per-vector combining, edge detection and request latch
  genvar gv;
  generate
    for (gv = 0; gv < NVEC; gv++) begin : g_vec
      logic [SENS_W-1:0] sens_f;
      logic rise;
      logic fall;
      assign sens_f = sens_r[SENS_W*gv +: SENS_W];
      // and of member pins: one low pin hides the others
      assign vec_lvl[gv] = &(det_in | ~vec_pins(gv));
      assign rise = vec_lvl[gv] && !prev_r[gv];
      assign fall = !vec_lvl[gv] && prev_r[gv];
      // event selection by the vector's sensitivity field
      always_comb begin
        case (gpx_sens_t'(sens_f))
          SENS_FALL_LOW: vec_evt[gv] = !vec_lvl[gv];
          SENS_RISE: vec_evt[gv] = rise;
          SENS_FALL: vec_evt[gv] = fall;
          SENS_BOTH: vec_evt[gv] = rise || fall;
          default: vec_evt[gv] = 1'b0;
        endcase
      end
      assign sens_chg[gv] = wr_sens &&
        (rb.wdata[SENS_W*gv +: SENS_W] != sens_f);
    end
  endgenerate

  // request latch: a new event wins over fetch or sensitivity clears
  always_comb begin
    prev_nxt = vec_lvl;
    pend_nxt = vec_evt |
               (pend_r & ~vec_fetch & ~sens_chg);
  end

  // interrupt flip-flops; detector history starts high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '1;
      pend_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      pend_r <= pend_nxt;
    end
  end

  // pad drive: alternate function first, then port programming
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (alt_out_en[i]) begin
        pad_out_nxt[i] = alt_out_val[i];
        pad_oe_nxt[i] = !(alt_open_drain[i] && alt_out_val[i]);
        pad_pu_nxt[i] = 1'b0;
      end else if (dir_r[i]) begin
        // option one push-pull, option zero open-drain
        pad_out_nxt[i] = data_r[i];
        pad_oe_nxt[i] = opt_r[i] || !data_r[i];
        pad_pu_nxt[i] = 1'b0;
      end else begin
        pad_out_nxt[i] = 1'b0;
        pad_oe_nxt[i] = 1'b0;
        pad_pu_nxt[i] = opt_r[i];
      end
    end
  end

  // pad flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
      pad_pu_r <= '0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      pad_pu_r <= pad_pu_nxt;
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pad_pullup_en = pad_pu_r;
  assign alt_in = pin_s;
  assign ext_irq_req = pend_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_oonly_out;
    dir_r[OUT_ONLY_PIN] && !pad_pu_r[OUT_ONLY_PIN];
  endproperty
  a_oonly_out: assert property (p_oonly_out)
    else $error("output-only pin left output mode");

  property p_pushpull;
    (dir_r[0] && opt_r[0] && !alt_out_en[0]) |=>
      (pad_oe_r[0] && pad_out_r[0] == $past(data_r[0]));
  endproperty
  a_pushpull: assert property (p_pushpull)
    else $error("push-pull pin does not follow latch");

  property p_od_float;
    (dir_r[1] && !opt_r[1] && data_r[1] && !alt_out_en[1]) |=> !pad_oe_r[1];
  endproperty
  a_od_float: assert property (p_od_float)
    else $error("open-drain high is driven");

  property p_input_hiz;
    (!dir_r[0] && !alt_out_en[0]) ##1 wr_data |=> !pad_oe_r[0];
  endproperty
  a_input_hiz: assert property (p_input_hiz)
    else $error("input pin driven after data write");

  property p_pullup;
    (!dir_r[2] && opt_r[2] && !alt_out_en[2]) |=> pad_pu_r[2];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up missing on interrupt input");

  property p_fetch_clr;
    (vec_fetch[1] && !vec_evt[1]) |=> !pend_r[1];
  endproperty
  a_fetch_clr: assert property (p_fetch_clr)
    else $error("fetch did not clear request");

  property p_sens_clr;
    (sens_chg[1] && !vec_evt[1]) |=> !pend_r[1] ##0 $changed(sens_r[3:2]);
  endproperty
  a_sens_clr: assert property (p_sens_clr)
    else $error("sensitivity change did not clear request");

  // option bit raised on a low input pin under falling sensitivity
  sequence s_enable_low;
    !dir_eff[2] && !pin_s[2] && $rose(opt_r[2]) &&
    sens_r[3:2] == SENS_FALL && prev_r[1];
  endsequence
  property p_spurious;
    s_enable_low |=> pend_r[1];
  endproperty
  a_spurious: assert property (p_spurious)
    else $error("detector edge from option toggle missed");

  property p_alt_prio;
    alt_out_en[4] |=> (pad_out_r[4] == $past(alt_out_val[4])) && !pad_pu_r[4];
  endproperty
  a_alt_prio: assert property (p_alt_prio)
    else $error("alternate output lost priority");
endmodule : gpx_port

// ==== core/gpx_pkg.sv ====
// constants, types and register map of the general purpose port
package gpx_pkg;
  localparam int NPINS = 6;
  localparam int NVEC = 3;
  localparam int OUT_ONLY_PIN = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IDX_W = 2;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DATA = 2'h0;
  localparam logic [IDX_W-1:0] IDX_DIR = 2'h1;
  localparam logic [IDX_W-1:0] IDX_OPT = 2'h2;
  localparam logic [IDX_W-1:0] IDX_SENS = 2'h3;
  localparam logic [1:0] BYTE_LANE_BITS = 2'h0;
  // reset values
  localparam logic [NPINS-1:0] RST_DATA = 6'h00;
  localparam logic [NPINS-1:0] RST_DIR = 6'h08;
  localparam logic [NPINS-1:0] RST_OPT = 6'h02;
  localparam logic [2*NVEC-1:0] RST_SENS = 6'h00;
  // sensitivity field width per vector
  localparam int SENS_W = 2;
  typedef enum logic [1:0] {
    SENS_FALL_LOW = 2'b00,
    SENS_RISE = 2'b01,
    SENS_FALL = 2'b10,
    SENS_BOTH = 2'b11
  } gpx_sens_t;
  // pins that feed each interrupt vector
  function automatic logic [NPINS-1:0] vec_pins(input int v);
    case (v)
      0: vec_pins = 6'h03;
      1: vec_pins = 6'h04;
      2: vec_pins = 6'h30;
      default: vec_pins = 6'h00;
    endcase
  endfunction : vec_pins
endpackage : gpx_pkg

// ==== core/gpx_regbus_if.sv ====
// internal register access channel between bus slave and port core
interface gpx_regbus_if;
  import gpx_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport core (input wr_en, input idx, input wdata, output rdata);
endinterface : gpx_regbus_if

// ==== core/gpx_sync.sv ====
// two-stage synchroniser for the pad inputs
module gpx_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [gpx_pkg::NPINS-1:0] d,
  output logic [gpx_pkg::NPINS-1:0] q
);
  import gpx_pkg::*;
  logic [NPINS-1:0] s1_r;
  logic [NPINS-1:0] s1_nxt;
  logic [NPINS-1:0] s2_r;
  logic [NPINS-1:0] s2_nxt;

  // next values: first stage only feeds the second
  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end

  // stage registers; they start high, the idle level of pulled-up inputs,
  // so the edge detector sees no false edge as reset ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;

  property p_two_stage;
    // the edge that leaves reset still loads reset values: start after it
    @(posedge pclk) disable iff (!presetn)
      presetn |-> ##2 (q == $past(d, 2));
  endproperty
  a_two_stage: assert property (p_two_stage)
    else $error("synchroniser is not two stages");
endmodule : gpx_sync

// ==== core/gpx_apb.sv ====
// apb slave with one wait state, feeding the register channel
module gpx_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gpx_regbus_if.slave rb
);
  import gpx_pkg::*;
  logic pready_r;
  logic pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic mapped;
  logic done;

  // decode: only word-aligned offsets of the four registers map; all others answer with pslverr
  assign mapped = (paddr[1:0] == BYTE_LANE_BITS) &&
                  (paddr[ADDR_W-1:IDX_W+2] == '0);
  assign done = psel && penable && pready_r;
  assign rb.idx = paddr[IDX_W+1:2];
  assign rb.wdata = pwdata[DATA_W-1:0];
  assign rb.wr_en = done && pwrite && mapped;

  // access phase waits one cycle, then answers with captured data
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && penable && !pready_r) begin
      prdata_nxt = (mapped && !pwrite) ? {24'h000000, rb.rdata} : 32'h0;
      pslverr_nxt = !mapped;
    end
  end

  // answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
endmodule : gpx_apb

// ==== verification/gpx_pins_model.sv ====
// pad world model: outside driver, pull-up and floating pins
module gpx_pins_model (
  input wire logic pclk,
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pad_pullup_en,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] flt_r = 6'h15;
  // an undriven pin wanders every cycle
  always @(posedge pclk) flt_r <= ~flt_r;
  // port drive wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flt_r[i];
    end
  end
endmodule : gpx_pins_model

// ==== verification/general_io_port_with_ext_irq_tb.sv ====
// self-checking bench for the six-pin port
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module general_io_port_with_ext_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [5:0] pad_in, pad_out, pad_oe, pad_pullup_en, alt_in;
  logic [5:0] aoe = 6'h00, aval = 6'h00, aod = 6'h00;
  logic [5:0] ee = 6'h37, ev = 6'h00;
  logic [2:0] fetch = 3'h0, ext_irq_req;
  logic [31:0] seed = 32'h0000AC27;
  logic [5:0] dx, opt, dat, oex, outx, pux, lvl, kn, rdx;
  logic [7:0] q;
  logic e;
  int err_total = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  gpx_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .alt_out_en(aoe),
    .alt_out_val(aval), .alt_open_drain(aod), .alt_in(alt_in),
    .vec_fetch(fetch), .ext_irq_req(ext_irq_req));
  gpx_pins_model pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_en(ee), .ext_val(ev),
    .pad_in(pad_in));
  // xorshift source for the random stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // expected pad enable: peripheral first, then port programming
  function automatic logic [5:0] exp_oe(input logic [5:0] ae, ad, av,
      dr, op, dt);
    return (ae & (~ad | ~av)) | (~ae & dr & (op | ~dt));
  endfunction : exp_oe
  // expected data read: peripheral value, latch, or known pin level
  function automatic logic [5:0] exp_rd(input logic [5:0] ae, av, dr, dt,
      lv);
    return (ae & av) | (~ae & dr & dt) | (~ae & ~dr & lv);
  endfunction : exp_rd
  // one apb transfer; pready and the answer are taken at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, d,
      output logic [7:0] rq, output logic re);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      tally_and_finish();
    end else begin
      rq = prdata[7:0];
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask : wr
  task automatic rd(input logic [7:0] a, m, x, input string nm);
    logic [7:0] rq;
    logic re;
    apb(1'b0, a, 8'h00, rq, re);
    `CHK(nm, x & m, rq & m)
  endtask : rd
  // drive outside pin levels and let them pass the synchroniser
  task automatic pin(input logic [5:0] v);
    @(posedge pclk);
    ev <= v;
    repeat (4) @(posedge pclk);
  endtask : pin
  task automatic vfetch(input logic [2:0] v);
    @(posedge pclk);
    fetch <= v;
    @(posedge pclk);
    fetch <= 3'h0;
  endtask : vfetch
  task automatic irq(input int n, input logic [2:0] x);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    `CHK("irq", x, ext_irq_req)
  endtask : irq
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, outside drives every input low
    rd(8'h00, 8'hFF, 8'h00, "data");
    rd(8'h04, 8'hFF, 8'h08, "dir");
    rd(8'h08, 8'hFF, 8'h02, "opt");
    rd(8'h0C, 8'hFF, 8'h00, "sens");
    $display("test reset values done");
    // unaligned and out-of-map places are refused
    apb(1'b0, 8'h10, 8'h00, q, e);
    `CHK("err", 1'b1, e)
    `CHK("rd_err", 8'h00, q)
    apb(1'b1, 8'h02, 8'h3F, q, e);
    `CHK("err", 1'b1, e)
    $display("test refused addresses done");
    // random pin setups with peripherals taking some pins
    for (int k = 0; k < 60; k++) begin
      dat = 6'(rnd());
      opt = 6'(rnd());
      dx = 6'(rnd());
      dx = dx | 6'h08;
      wr(8'h00, {2'b00, dat});
      wr(8'h08, {2'b00, opt});
      wr(8'h04, {2'b00, dx & 6'h37});
      aoe <= 6'(rnd() & rnd());
      aval <= 6'(rnd());
      aod <= 6'(rnd());
      @(posedge pclk);
      oex = exp_oe(aoe, aod, aval, dx, opt, dat);
      outx = (aoe & ~aod & aval) | (~aoe & opt & dat);
      pux = ~dx & opt;
      ee <= 6'(rnd()) & ~oex;
      ev <= 6'(rnd());
      repeat (4) @(posedge pclk);
      lvl = (oex & outx) | (~oex & ee & ev) | (~oex & ~ee & pux);
      kn = oex | ee | (pux & ~aoe);
      rdx = exp_rd(aoe, aval, dx, dat, lvl);
      @(negedge pclk);
      `CHK("oe", oex, pad_oe)
      `CHK("out", outx & oex, pad_out & oex)
      `CHK("pu", pux & ~aoe, pad_pullup_en & ~aoe)
      `CHK("alt_in", lvl & kn, alt_in & kn)
      kn = kn | aoe | dx;
      rd(8'h00, {2'b11, kn}, {2'b00, rdx}, "data");
      rd(8'h04, 8'hFF, {2'b00, dx}, "dir");
    end
    $display("test random pin setups done");
    // interrupt paths, all pins but output-only pin 3 input and held high
    aoe <= 6'h00;
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    ee <= 6'h37;
    pin(6'h37);
    // outside-driven inputs hand peripherals the synchronised level
    @(negedge pclk);
    `CHK("alt_in", 6'h37, alt_in & 6'h37)
    rd(8'h00, 8'h37, 8'h37, "data");
    vfetch(3'h7);
    irq(2, 3'h0);
    wr(8'h0C, 8'h04);
    wr(8'h08, 8'h04);
    pin(6'h33);
    irq(0, 3'h0);
    pin(6'h37);
    irq(0, 3'h2);
    vfetch(3'h2);
    irq(1, 3'h0);
    pin(6'h33);
    pin(6'h37);
    wr(8'h0C, 8'h08);
    irq(1, 3'h0);
    pin(6'h33);
    irq(0, 3'h2);
    vfetch(3'h2);
    wr(8'h08, 8'h00);
    irq(2, 3'h0);
    wr(8'h0C, 8'h04);
    wr(8'h0C, 8'h08);
    wr(8'h08, 8'h04);
    irq(2, 3'h2);
    vfetch(3'h2);
    wr(8'h0C, 8'h00);
    vfetch(3'h2);
    irq(2, 3'h2);
    pin(6'h37);
    vfetch(3'h2);
    irq(2, 3'h0);
    $display("test single pin vector done");
    // two pins on one vector: a low pin hides the other
    wr(8'h0C, 8'h01);
    wr(8'h08, 8'h03);
    pin(6'h36);
    pin(6'h34);
    pin(6'h36);
    irq(0, 3'h0);
    pin(6'h37);
    irq(0, 3'h1);
    // both edges: a fall and a rise each raise the request
    vfetch(3'h1);
    wr(8'h0C, 8'h03);
    pin(6'h36);
    irq(0, 3'h1);
    vfetch(3'h1);
    pin(6'h37);
    irq(0, 3'h1);
    $display("test shared vector done");
    tally_and_finish();
  end
endmodule : general_io_port_with_ext_irq_tb
